//--- src/flash_lock_params.svh
// Purpose: Named constants for the flash page lock protection block
// Assumes: 16-bit flash byte addresses, 512-byte pages, AXI4-Lite register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
`ifndef FLASH_LOCK_PARAMS_SVH
`define FLASH_LOCK_PARAMS_SVH

// ****************************************
// Flash geometry
// ****************************************
`define FLASH_ADDR_W 16
`define PAGE_SHIFT 9
`define LOCK_BYTE_ADDR 16'h1dff
`define LOCK_ERASED 8'hff

// ****************************************
// Key sequence
// ****************************************
`define KEY_FIRST 8'ha5
`define KEY_SECOND 8'hf1
`define KEY_LOCKED 2'b00
`define KEY_HALF 2'b01
`define KEY_OPEN 2'b10
`define KEY_DEAD 2'b11

// ****************************************
// Register map and fields
// ****************************************
`define REG_ADDR_W 8
`define OFS_STORE_CTRL 8'h00
`define OFS_KEY_SEQ 8'h04
`define OFS_RESET_CAUSE 8'h08
`define OFS_LOCK_STATUS 8'h0c
`define SCR_WE_BIT 0
`define SCR_EE_BIT 1
`define RCR_FAULT_BIT 6
`define LST_ANY_BIT 8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- src/flash_lock_pkg.sv
// Purpose: Types shared by the flash page lock protection block and its bench
// Assumes: flash_lock_params.svh supplies every width
// Notes: Requests travel as req_t, flash commands as flash_cmd_t
`include "flash_lock_params.svh"

package flash_lock_pkg;

	// ****************************************
	// Request carriers
	// ****************************************
	typedef enum logic [2:0] {
		OP_CODE_READ = 3'h0,
		OP_XDATA_READ = 3'h1,
		OP_XDATA_WRITE = 3'h2,
		OP_DBG_READ = 3'h3,
		OP_DBG_WRITE = 3'h4,
		OP_DBG_ERASE = 3'h5,
		OP_DBG_ERASE_ALL = 3'h6
	} op_t;

	typedef enum logic [1:0] {
		FL_READ = 2'h0,
		FL_WRITE = 2'h1,
		FL_ERASE = 2'h2,
		FL_ERASE_ALL = 2'h3
	} flash_op_t;

	typedef struct packed {
		op_t op;
		logic [`FLASH_ADDR_W-1:0] addr;
		logic [`FLASH_ADDR_W-1:0] fetch_addr;
		logic [7:0] data;
	} req_t;

	typedef struct packed {
		flash_op_t op;
		logic [`FLASH_ADDR_W-1:0] addr;
		logic [7:0] data;
	} flash_cmd_t;

	typedef struct packed {
		logic ok;
		logic [7:0] rdata;
	} resp_t;

	// ****************************************
	// Control states
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_FLASH = 3'b010,
		S_HALT = 3'b100
	} state_t;

endpackage

//--- src/flash_page_lock_protection.sv
// Purpose: Checks every flash read, write and page erase against the page lock state; debug device erase is passed unchecked
// Assumes: Requesters hold request fields stable while valid; flash_done pulses once per command
// Notes: Function
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns

module flash_page_lock_protection
	import flash_lock_pkg::*;
#(
	parameter logic [`FLASH_ADDR_W-1:0] LOCK_ADDR = `LOCK_BYTE_ADDR,
	parameter int IRQ_N = 8
) (
	// Clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	// Firmware requester
	input wire logic fw_valid,
	input req_t fw_req,
	output logic fw_ready,
	output logic fw_resp_valid,
	output resp_t fw_resp,
	// Debug port requester
	input wire logic dbg_valid,
	input req_t dbg_req,
	output logic dbg_ready,
	output logic dbg_resp_valid,
	output resp_t dbg_resp,
	output logic dbg_drop,
	// Flash array
	input wire logic [7:0] lock_byte_in,
	output logic flash_valid,
	output flash_cmd_t flash_cmd,
	input wire logic flash_done,
	input wire logic [7:0] flash_rdata,
	// External data RAM
	output logic external_data_ram_valid,
	output logic external_data_ram_we,
	output logic [`FLASH_ADDR_W-1:0] external_data_ram_addr,
	output logic [7:0] external_data_ram_wdata,
	// Reset and interrupt side
	output logic fault_reset_req,
	input wire logic [IRQ_N-1:0] irq_in,
	output logic [IRQ_N-1:0] irq_out,
	// AXI4-Lite slave
	input wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		state_t fsm;
		logic sampled;
		logic [7:0] lock_byte;
		logic lock_written;
		logic fault_cause;
		logic fault_flag;
		logic store_write_enable;
		logic store_erase_enable;
		logic [1:0] key_state;
		logic cur_dbg;
		flash_cmd_t cmd;
		logic fw_resp_valid;
		logic dbg_resp_valid;
		resp_t resp;
		logic fault_req;
		logic dbg_drop;
		logic external_data_ram_valid;
		logic external_data_ram_we;
		logic [`FLASH_ADDR_W-1:0] external_data_ram_addr;
		logic [7:0] external_data_ram_wdata;
		logic [IRQ_N-1:0] irq_pend;
		logic aw_got;
		logic [`REG_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} flash_lock_state_t;

	flash_lock_state_t st_reg;
	flash_lock_state_t st_next;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] page_of(input logic [`FLASH_ADDR_W-1:0] a);
		page_of = 8'(a >> `PAGE_SHIFT);
	endfunction

	function automatic logic any_locked(input logic [7:0] lb);
		any_locked = (lb != `LOCK_ERASED);
	endfunction

	function automatic logic page_locked(input logic [`FLASH_ADDR_W-1:0] a, input logic [7:0] lb);
		logic [7:0] n;
		n = ~lb;
		if (page_of(a) == page_of(LOCK_ADDR)) begin
			page_locked = any_locked(lb);
		end else begin
			page_locked = (page_of(a) < n);
		end
	endfunction

	function automatic logic is_reserved(input logic [`FLASH_ADDR_W-1:0] a);
		is_reserved = (a > LOCK_ADDR);
	endfunction

	function automatic logic reg_mapped(input logic [`REG_ADDR_W-1:0] a);
		reg_mapped = (a == `OFS_STORE_CTRL) || (a == `OFS_KEY_SEQ) ||
			(a == `OFS_RESET_CAUSE) || (a == `OFS_LOCK_STATUS);
	endfunction

	// ****************************************
	// Handshakes and outputs
	// ****************************************
	assign dbg_ready = (st_reg.fsm == S_IDLE) && st_reg.sampled;
	assign fw_ready = (st_reg.fsm == S_IDLE) && st_reg.sampled && !dbg_valid;
	assign flash_valid = (st_reg.fsm == S_FLASH);
	assign flash_cmd = st_reg.cmd;
	assign fw_resp_valid = st_reg.fw_resp_valid;
	assign fw_resp = st_reg.resp;
	assign dbg_resp_valid = st_reg.dbg_resp_valid;
	assign dbg_resp = st_reg.resp;
	assign dbg_drop = st_reg.dbg_drop;
	assign fault_reset_req = st_reg.fault_req;
	assign external_data_ram_valid = st_reg.external_data_ram_valid;
	assign external_data_ram_we = st_reg.external_data_ram_we;
	assign external_data_ram_addr = st_reg.external_data_ram_addr;
	assign external_data_ram_wdata = st_reg.external_data_ram_wdata;
	assign irq_out = (st_reg.fsm == S_FLASH) ? '0 : (st_reg.irq_pend | irq_in);
	assign s_axi_awready = !st_reg.aw_got;
	assign s_axi_wready = !st_reg.w_got;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic fw_mod;
		logic tgt_locked;
		logic run_locked;
		logic lock_page;
		logic [31:0] rd;
		fw_mod = 1'b0;
		tgt_locked = 1'b0;
		run_locked = 1'b0;
		lock_page = 1'b0;
		rd = 32'h0000_0000;
		st_next = st_reg;
		st_next.fw_resp_valid = 1'b0;
		st_next.dbg_resp_valid = 1'b0;
		st_next.fault_req = 1'b0;
		st_next.dbg_drop = 1'b0;
		st_next.external_data_ram_valid = 1'b0;

		// lock byte captured once after reset
		if (!st_reg.sampled) begin
			st_next.sampled = 1'b1;
			st_next.lock_byte = lock_byte_in;
			st_next.lock_written = any_locked(lock_byte_in);
			st_next.fault_cause = 1'b0;
		end

		if (st_reg.fsm == S_FLASH) begin
			st_next.irq_pend = st_reg.irq_pend | irq_in;
		end else begin
			st_next.irq_pend = '0;
		end

		case (st_reg.fsm)
			S_IDLE: begin
				if (dbg_valid && dbg_ready) begin
					tgt_locked = page_locked(dbg_req.addr, st_reg.lock_byte);
					lock_page = (page_of(dbg_req.addr) == page_of(LOCK_ADDR));
					st_next.cur_dbg = 1'b1;
					st_next.cmd.addr = dbg_req.addr;
					st_next.cmd.data = dbg_req.data;
					st_next.fsm = S_FLASH;
					if (dbg_req.op == OP_DBG_ERASE_ALL) begin
						st_next.cmd.op = FL_ERASE_ALL;
					end else if (is_reserved(dbg_req.addr) || tgt_locked ||
						(dbg_req.op == OP_DBG_WRITE && dbg_req.addr == LOCK_ADDR && st_reg.lock_written)) begin
						st_next.fsm = S_IDLE;
						st_next.dbg_drop = 1'b1;
						st_next.dbg_resp_valid = 1'b1;
						st_next.resp = '{ok: 1'b0, rdata: 8'h00};
					end else if (dbg_req.op == OP_DBG_ERASE) begin
						// page erase of an unlocked page, the lock page only when nothing locked
						st_next.cmd.op = FL_ERASE;
					end else if (dbg_req.op == OP_DBG_WRITE) begin
						st_next.cmd.op = FL_WRITE;
					end else begin
						st_next.cmd.op = FL_READ;
					end
					if (lock_page && dbg_req.op == OP_DBG_ERASE && st_next.fsm == S_FLASH) begin
						st_next.lock_written = 1'b0;
					end
				end else if (fw_valid && fw_ready) begin
					run_locked = page_locked(fw_req.fetch_addr, st_reg.lock_byte);
					tgt_locked = page_locked(fw_req.addr, st_reg.lock_byte);
					lock_page = (page_of(fw_req.addr) == page_of(LOCK_ADDR));
					st_next.cur_dbg = 1'b0;
					st_next.cmd.addr = fw_req.addr;
					st_next.cmd.data = fw_req.data;
					fw_mod = (fw_req.op == OP_XDATA_WRITE) && st_reg.store_write_enable;
					if (fw_req.op == OP_XDATA_READ || (fw_req.op == OP_XDATA_WRITE && !fw_mod)) begin
						st_next.external_data_ram_valid = 1'b1;
						st_next.external_data_ram_we = (fw_req.op == OP_XDATA_WRITE);
						st_next.external_data_ram_addr = fw_req.addr;
						st_next.external_data_ram_wdata = fw_req.data;
						st_next.fw_resp_valid = 1'b1;
						st_next.resp = '{ok: 1'b1, rdata: 8'h00};
					end else if (is_reserved(fw_req.addr) ||
						(fw_mod && st_reg.store_erase_enable && lock_page) ||
						(fw_mod && !st_reg.store_erase_enable && fw_req.addr == LOCK_ADDR && st_reg.lock_written) ||
						(tgt_locked && !run_locked)) begin
						st_next.fault_req = 1'b1;
						st_next.fault_cause = 1'b1;
						st_next.fsm = S_HALT;
					end else if (fw_mod && st_reg.key_state != `KEY_OPEN) begin
						st_next.key_state = `KEY_DEAD;
						st_next.fw_resp_valid = 1'b1;
						st_next.resp = '{ok: 1'b0, rdata: 8'h00};
					end else begin
						st_next.fsm = S_FLASH;
						if (!fw_mod) begin
							st_next.cmd.op = FL_READ;
						end else if (st_reg.store_erase_enable) begin
							st_next.cmd.op = FL_ERASE;
						end else begin
							st_next.cmd.op = FL_WRITE;
						end
					end
				end
			end
			S_FLASH: begin
				if (flash_done) begin
					st_next.fsm = S_IDLE;
					st_next.resp = '{ok: 1'b1, rdata: flash_rdata};
					st_next.dbg_resp_valid = st_reg.cur_dbg;
					st_next.fw_resp_valid = !st_reg.cur_dbg;
					if (!st_reg.cur_dbg && st_reg.cmd.op != FL_READ) begin
						st_next.key_state = `KEY_LOCKED;
					end
					if (st_reg.cmd.op == FL_WRITE && st_reg.cmd.addr == LOCK_ADDR) begin
						st_next.lock_written = 1'b1;
					end
					if (st_reg.cmd.op == FL_ERASE_ALL) begin
						st_next.lock_byte = `LOCK_ERASED;
						st_next.lock_written = 1'b0;
					end
				end
			end
			S_HALT: begin
				// Waits for the system reset it asked for
				st_next.fsm = S_HALT;
			end
			default: begin
				st_next.fsm = S_IDLE;
			end
		endcase

		// ****************************************
		// AXI4-Lite register slave
		// ****************************************
		if (s_axi_awvalid && !st_reg.aw_got) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_got) begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = reg_mapped(st_reg.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			if (st_reg.w_strb[0]) begin
				if (st_reg.aw_addr == `OFS_STORE_CTRL) begin
					st_next.store_write_enable = st_reg.w_data[`SCR_WE_BIT];
					st_next.store_erase_enable = st_reg.w_data[`SCR_EE_BIT];
				end else if (st_reg.aw_addr == `OFS_KEY_SEQ) begin
					if (st_next.key_state == `KEY_LOCKED && st_reg.w_data[7:0] == `KEY_FIRST) begin
						st_next.key_state = `KEY_HALF;
					end else if (st_next.key_state == `KEY_HALF && st_reg.w_data[7:0] == `KEY_SECOND) begin
						st_next.key_state = `KEY_OPEN;
					end else begin
						st_next.key_state = `KEY_DEAD;
					end
				end
			end
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_reg.rvalid) begin
			if (s_axi_araddr == `OFS_STORE_CTRL) begin
				rd[`SCR_WE_BIT] = st_reg.store_write_enable;
				rd[`SCR_EE_BIT] = st_reg.store_erase_enable;
			end else if (s_axi_araddr == `OFS_KEY_SEQ) begin
				rd[1:0] = st_reg.key_state;
			end else if (s_axi_araddr == `OFS_RESET_CAUSE) begin
				rd[`RCR_FAULT_BIT] = st_reg.fault_flag;
			end else if (s_axi_araddr == `OFS_LOCK_STATUS) begin
				rd[7:0] = st_reg.lock_byte;
				rd[`LST_ANY_BIT] = any_locked(st_reg.lock_byte);
			end
			st_next.rvalid = 1'b1;
			st_next.rdata = rd;
			st_next.rresp = reg_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end

		// ****************************************
		// Resets
		// ****************************************
		// the cause survives one system reset in fault_flag; power-on or the next system reset clears it
		if (!aresetn || !por_n) begin
			st_next = '0;
			st_next.fsm = S_IDLE;
			st_next.key_state = `KEY_LOCKED;
			st_next.lock_byte = `LOCK_ERASED;
			if (por_n) begin
				st_next.fault_cause = st_reg.fault_cause;
				st_next.fault_flag = st_reg.fault_cause;
			end
		end
	end

	always_ff @(posedge aclk) begin
		st_reg <= st_next;
	end

endmodule // flash_page_lock_protection

//--- verif/flash_lock_checker_properties.sv
// Purpose: Port checks for the flash page lock protection block
// Assumes: Bound inside every instance of the block
// Notes: One clock domain, so default clocking and disable
`timescale 1ns/1ns
`include "flash_lock_params.svh"

module flash_lock_checker
	import flash_lock_pkg::*;
#(
	parameter logic [`FLASH_ADDR_W-1:0] LOCK_ADDR = `LOCK_BYTE_ADDR,
	parameter int IRQ_N = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Requesters
	input wire logic fw_valid,
	input req_t fw_req,
	input wire logic fw_ready,
	input wire logic fw_resp_valid,
	input wire logic dbg_valid,
	input req_t dbg_req,
	input wire logic dbg_ready,
	input wire logic dbg_resp_valid,
	input wire logic dbg_drop,
	// Flash and system side
	input wire logic flash_valid,
	input flash_cmd_t flash_cmd,
	input wire logic flash_done,
	input wire logic external_data_ram_valid,
	input wire logic fault_reset_req,
	input wire logic [IRQ_N-1:0] irq_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_drop_quiet;
		dbg_drop |-> !fault_reset_req;
	endproperty
	a_drop_quiet: assert property (p_drop_quiet) else $error("drop came with reset");
	property p_irq_hold;
		flash_valid |-> irq_out == '0;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq passed during flash op");
	property p_dbg_reserved;
		dbg_valid && dbg_ready && dbg_req.addr > LOCK_ADDR && dbg_req.op != OP_DBG_ERASE_ALL |=> dbg_drop && !flash_valid;
	endproperty
	a_dbg_reserved: assert property (p_dbg_reserved) else $error("debug reserved access not dropped");
	property p_fw_reserved;
		fw_valid && fw_ready && fw_req.addr > LOCK_ADDR && fw_req.op == OP_CODE_READ |=> fault_reset_req && !flash_valid;
	endproperty
	a_fw_reserved: assert property (p_fw_reserved) else $error("firmware reserved read not faulted");
	property p_fault_halt;
		fault_reset_req |=> (!fw_ready && !dbg_ready) [*4];
	endproperty
	a_fault_halt: assert property (p_fault_halt) else $error("requests taken after fault");
	property p_external_data_ram_read;
		fw_valid && fw_ready && fw_req.op == OP_XDATA_READ |=> external_data_ram_valid && !flash_valid;
	endproperty
	a_external_data_ram_read: assert property (p_external_data_ram_read) else $error("external read reached flash");
	property p_flash_answer;
		flash_valid && flash_done |=> fw_resp_valid != dbg_resp_valid;
	endproperty
	a_flash_answer: assert property (p_flash_answer) else $error("no single answer after flash done");
	property p_erase_all;
		dbg_valid && dbg_ready && dbg_req.op == OP_DBG_ERASE_ALL |=> flash_valid && flash_cmd.op == FL_ERASE_ALL;
	endproperty
	a_erase_all: assert property (p_erase_all) else $error("device erase not issued");
endmodule // flash_lock_checker

bind flash_page_lock_protection flash_lock_checker #(.LOCK_ADDR(LOCK_ADDR), .IRQ_N(IRQ_N)) u_checker (
	.aclk, .aresetn, .fw_valid, .fw_req, .fw_ready, .fw_resp_valid, .dbg_valid, .dbg_req, .dbg_ready,
	.dbg_resp_valid, .dbg_drop, .flash_valid, .flash_cmd, .flash_done, .external_data_ram_valid, .fault_reset_req, .irq_out
);

//--- verif/flash_model.sv
// Purpose: Behavioural flash array facing the protection block
// Assumes: One command at a time, held until done
// Notes: Idle read data toggles so a stale byte never passes
`timescale 1ns/1ns
`include "flash_lock_params.svh"

module flash_model
	import flash_lock_pkg::*;
#(
	parameter logic [7:0] LOCK_INIT = 8'hfd
) (
	// Clock and command
	input wire logic aclk,
	input wire logic flash_valid,
	input flash_cmd_t flash_cmd,
	input wire logic [1:0] delay,
	// Answer
	output logic flash_done,
	output logic [7:0] flash_rdata,
	output logic [7:0] lock_byte_in
);
	logic [7:0] mem [0:65535];
	int cnt;
	assign lock_byte_in = mem[`LOCK_BYTE_ADDR];
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		mem[`LOCK_BYTE_ADDR] = LOCK_INIT;
		flash_done = 1'b0;
		flash_rdata = 8'h00;
		cnt = 0;
	end
	always @(posedge aclk) begin
		flash_done <= 1'b0;
		flash_rdata <= ~flash_rdata;
		if (flash_valid && !flash_done) begin
			if (cnt < delay) begin
				cnt++;
			end else begin
				cnt = 0;
				flash_done <= 1'b1;
				case (flash_cmd.op)
					FL_READ: flash_rdata <= mem[flash_cmd.addr];
					// Programming only clears bits
					FL_WRITE: mem[flash_cmd.addr] &= flash_cmd.data;
					FL_ERASE: for (int i = 0; i < 512; i++) mem[{flash_cmd.addr[15:9], 9'(i)}] = 8'hff;
					default: foreach (mem[i]) mem[i] = 8'hff;
				endcase
			end
		end
	end
endmodule // flash_model

//--- verif/test_flash_page_lock_protection.sv
// Purpose: Self-checking bench for the flash page lock protection block
// Assumes: flash_model plays the array, bench drives both requesters
// Notes: Outcomes predicted by a small lock model in integers
`timescale 1ns/1ns
`include "flash_lock_params.svh"

module test_flash_page_lock_protection
	import flash_lock_pkg::*;
;
	localparam int LK = `LOCK_BYTE_ADDR;
	logic aclk, aresetn, por_n, fw_valid, fw_ready, fw_resp_valid, dbg_valid, dbg_ready, dbg_resp_valid, dbg_drop;
	logic flash_valid, flash_done, external_data_ram_valid, external_data_ram_we, fault_reset_req;
	logic [15:0] external_data_ram_addr;
	logic [24:0] xa;
	req_t fw_req, dbg_req;
	resp_t fw_resp, dbg_resp;
	flash_cmd_t flash_cmd;
	logic [7:0] lock_byte_in, flash_rdata, irq_in, irq_out, s_axi_awaddr, s_axi_araddr, rd, external_data_ram_wdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, dly;
	int failures, samples_checked, got, lock_s, lock_b;
	int seed = 32'h5866f0ea;
	bit wrt, kopen, we, ee;

	flash_page_lock_protection i_dut (
		.aclk, .aresetn, .por_n, .fw_valid, .fw_req, .fw_ready, .fw_resp_valid, .fw_resp, .dbg_valid, .dbg_req,
		.dbg_ready, .dbg_resp_valid, .dbg_resp, .dbg_drop, .lock_byte_in, .flash_valid, .flash_cmd, .flash_done,
		.flash_rdata, .external_data_ram_valid, .external_data_ram_we, .external_data_ram_addr, .external_data_ram_wdata, .fault_reset_req, .irq_in, .irq_out,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	flash_model i_flash (.aclk, .flash_valid, .flash_cmd, .delay(dly), .flash_done, .flash_rdata, .lock_byte_in);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) irq_in <= 8'($random(seed));

	task automatic stop_test();
		$display("checked %0d values, %0d failures", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic to();
		failures++;
		stop_test();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	// Master holds each channel until its own ready edge
	task automatic ax(input bit w, input logic [7:0] a, input logic [31:0] d);
		int n;
		bit t1, t2, b;
		@(posedge aclk);
		if (w) begin
			{s_axi_awaddr, s_axi_wdata} <= {a, d};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		end else begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
		end
		n = 0;
		do begin
			@(negedge aclk);
			t1 = w ? s_axi_awready : s_axi_arready;
			t2 = s_axi_wready;
			b = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (w && t1) s_axi_awvalid <= 1'b0;
			if (w && t2) s_axi_wvalid <= 1'b0;
			if (!w && t1) s_axi_arvalid <= 1'b0;
			n++;
		end while (!b && n < 40);
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (!b) to();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ax(1, a, d);
		chk(r, `RESP_OKAY);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		ax(0, a, 0);
		chk(q, e);
	endtask
	task automatic key();
		wr(`OFS_KEY_SEQ, `KEY_FIRST);
		wr(`OFS_KEY_SEQ, `KEY_SECOND);
		kopen = 1;
	endtask
	task automatic setc(input logic [1:0] v);
		wr(`OFS_STORE_CTRL, v);
		{ee, we} = v;
	endtask
	task automatic rst(input bit por);
		@(posedge aclk);
		aresetn <= 1'b0;
		por_n <= !por;
		repeat (4) @(posedge aclk);
		{aresetn, por_n} <= 2'h3;
		lock_s = lock_b;
		wrt = lock_b != 'hff;
		{kopen, we, ee} = '0;
	endtask
	function automatic bit lk(int a);
		return (a >> 9) < (~lock_s & 'hff) || (lock_s != 'hff && (a >> 9) == (LK >> 9));
	endfunction
	// Outcome: 0 granted, 1 refused, 2 fault reset, 3 external RAM
	function automatic int want(bit d, op_t op, int a, int f, bit md);
		bit er;
		er = op == OP_DBG_ERASE || (op == OP_XDATA_WRITE && we && ee);
		if (op == OP_DBG_ERASE_ALL) return 0;
		if (op == OP_XDATA_READ || (op == OP_XDATA_WRITE && !we)) return 3;
		if (d) return (a > LK || lk(a) || (a == LK && md && wrt)) ? 1 : 0;
		if (a > LK || (er && (a >> 9) == (LK >> 9)) || (a == LK && md && wrt) || (lk(a) && !lk(f))) return 2;
		return (md && !kopen) ? 1 : 0;
	endfunction
	task automatic go(input bit d, input op_t op, input int a, input int f, input logic [7:0] wd);
		int n, e;
		bit md, dr;
		md = op inside {OP_DBG_WRITE, OP_DBG_ERASE} || (op == OP_XDATA_WRITE && we);
		e = want(d, op, a, f, md);
		@(posedge aclk);
		dly <= 2'($random(seed));
		if (d) dbg_req <= '{op, 16'(a), 16'(f), wd};
		else fw_req <= '{op, 16'(a), 16'(f), wd};
		if (d) dbg_valid <= 1'b1;
		else fw_valid <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!(d ? dbg_ready : fw_ready) && n < 60);
		@(posedge aclk);
		{dbg_valid, fw_valid} <= 2'h0;
		got = 9;
		while (got == 9 && n < 120) begin
			@(negedge aclk);
			n++;
			rd = d ? dbg_resp.rdata : fw_resp.rdata;
			dr = dbg_drop;
			xa = {external_data_ram_we, external_data_ram_addr, external_data_ram_wdata};
			if (fault_reset_req) got = 2;
			else if (external_data_ram_valid) got = 3;
			else if (d ? dbg_resp_valid : fw_resp_valid) got = (d ? dbg_resp.ok : fw_resp.ok) ? 0 : 1;
		end
		if (got == 9) to();
		chk(got, e);
		if (d) chk(dr, e == 1);
		if (e == 3) chk(xa, {op == OP_XDATA_WRITE, 16'(a), wd});
		if (e == 0 && md) kopen = 0;
		if (e == 0 && md && a == LK) {wrt, lock_b} = {1'b1, lock_b & wd};
		if (op == OP_DBG_ERASE_ALL) {wrt, lock_s, lock_b} = {1'b0, 32'hff, 32'hff};
	endtask
	task automatic fault(input op_t op, input int a, input int f);
		go(0, op, a, f, 0);
		rst(0);
		ax(0, `OFS_RESET_CAUSE, 0);
		chk(q & 32'h40, 32'h40);
		rst(1);
		ax(0, `OFS_RESET_CAUSE, 0);
		chk(q & 32'h40, 32'h0);
	endtask

	initial begin
		{aresetn, por_n, fw_valid, dbg_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, fw_req, dbg_req, irq_in, dly, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{failures, samples_checked} = '0;
		lock_b = 'hfd;
		rst(1);
		rdchk(`OFS_STORE_CTRL, 0);
		rdchk(`OFS_LOCK_STATUS, 32'h1fd);
		ax(0, 8'h20, 0);
		chk(r, `RESP_SLVERR);
		go(1, OP_DBG_READ, 'h0100, 0, 0);
		go(1, OP_DBG_READ, 'h0400, 0, 0);
		go(1, OP_DBG_READ, LK, 0, 0);
		go(1, OP_DBG_READ, 'h1e00, 0, 0);
		go(1, OP_DBG_WRITE, 'h1c10, 0, 8'h00);
		go(1, OP_DBG_ERASE, 'h1c00, 0, 0);
		go(0, OP_CODE_READ, LK, 'h0000, 0);
		chk(rd, 8'hfd);
		go(0, OP_XDATA_READ, 'h0200, 'h0000, 0);
		setc(1);
		go(0, OP_XDATA_WRITE, 'h0500, 'h0400, 8'h3c);
		rdchk(`OFS_KEY_SEQ, `KEY_DEAD);
		rst(0);
		key();
		rdchk(`OFS_KEY_SEQ, `KEY_OPEN);
		setc(1);
		go(0, OP_XDATA_WRITE, 'h0500, 'h0400, 8'h3c);
		rdchk(`OFS_KEY_SEQ, `KEY_LOCKED);
		go(0, OP_CODE_READ, 'h0500, 'h1000, 0);
		chk(rd, 8'h3c);
		key();
		setc(3);
		go(0, OP_XDATA_WRITE, 'h05a0, 'h0400, 8'h00);
		setc(2);
		go(0, OP_XDATA_WRITE, 'h0500, 'h0400, 8'h00);
		go(0, OP_CODE_READ, 'h0500, 'h0400, 0);
		chk(rd, 8'hff);
		key();
		setc(1);
		go(0, OP_XDATA_WRITE, 'h0100, 'h0000, 8'h5a);
		fault(OP_CODE_READ, 'h0200, 'h0400);
		fault(OP_CODE_READ, LK, 'h0400);
		fault(OP_CODE_READ, 'h1e00, 'h0000);
		key();
		setc(3);
		fault(OP_XDATA_WRITE, 'h1c40, 'h0000);
		go(1, OP_DBG_ERASE_ALL, 0, 0, 0);
		rdchk(`OFS_LOCK_STATUS, 32'h0ff);
		go(1, OP_DBG_READ, 'h0100, 0, 0);
		chk(rd, 8'hff);
		key();
		setc(1);
		go(0, OP_XDATA_WRITE, LK, 'h0400, 8'hfe);
		rdchk(`OFS_LOCK_STATUS, 32'h0ff);
		go(1, OP_DBG_WRITE, LK, 0, 8'h00);
		rst(0);
		rdchk(`OFS_LOCK_STATUS, 32'h1fe);
		go(1, OP_DBG_READ, 'h0000, 0, 0);
		go(1, OP_DBG_READ, 'h0200, 0, 0);
		stop_test();
	end
endmodule // test_flash_page_lock_protection
